// ==== logic/tcps_pkg.sv ====
// tcps_pkg: constants, enums and structs for the type-c strap and status block
// assumes tri-level strap pins arrive already digitised as low/mid/high codes
//
// Operation
// RQ1: role strap high gives source, floating gives dual-role, low gives sink
// RQ2: role strap sampled on cc enable with 5 V present, and on soft reset; code samples on soft reset only while enabled
// RQ3: pin mode source advertises 900 mA, 1.5 A or 3 A; ignored as sink
// RQ4: address strap high gives 0x67, low gives 0x47, floating gives pin mode
// RQ5: serial mode drives shared pin as active-low register-change interrupt
// RQ6: pin mode drives shared pin low while audio accessory is attached
// RQ7: pin mode sink drives status a high for default current, else low
// RQ8: pin mode sink drives status b low only for high current
// RQ9: fault output pulled low on cable supply overcurrent
// RQ10: attach output pulled low when sink attached while acting as source
// RQ11: orientation reported on open-drain output needing external pull-up
// RQ12: mux runs while its enable is low, shut down while high
// RQ13: cc controller enabled only while its active-low enable is low
// RQ14: bus voltage sense marks attach in sink role
// RQ15: dual-role alternates source and sink until attach detected
// RQ16: orientation from terminated cc wire sets mux select after attach
// RQ17: strap values held latched between sampling events
package tcps_pkg;
	typedef enum logic [1:0] {TRI_LOW, TRI_MID, TRI_HIGH, TRI_BAD} tcps_tri_t;
	typedef enum logic [1:0] {ROLE_SRC, ROLE_DRP, ROLE_SNK} tcps_role_t;
	typedef enum logic [1:0] {CUR_DEF, CUR_MED, CUR_HIGH} tcps_cur_t;
	typedef enum logic [1:0] {ST_OFF, ST_UNATT_SRC, ST_UNATT_SNK, ST_ATTACHED} tcps_state_t;

	localparam logic [6:0] ADDR_STRAP_HIGH = 7'h67;
	localparam logic [6:0] ADDR_STRAP_LOW = 7'h47;
	localparam int TOGGLE_NS = 50000;
	localparam int CLK_NS = 5;
	localparam int TOGGLE_CYC = TOGGLE_NS / CLK_NS;
	localparam int TOGGLE_W = 14;

	typedef struct packed {
		tcps_role_t role;
		logic serial_mode;
		logic [6:0] dev_addr;
	} tcps_cfg_t;

	typedef struct packed {
		logic cc1_rd;
		logic cc2_rd;
		logic cc1_rp;
		logic cc2_rp;
		tcps_cur_t cur;
		logic audio;
	} tcps_cc_t;

	typedef struct packed {
		logic irq_or_audio_status_pin_oe;
		logic current_status_a_oe;
		logic current_status_b_oe;
		logic cable_supply_fault_n_oe;
		logic source_attach_n_oe;
		logic orient_oe;
	} tcps_od_t;
endpackage : tcps_pkg

// ==== logic/tcps_top.sv ====
// tcps_top: strap latching, role toggling and open-drain status drive
// assumes cc comparator results and straps are synchronous to clock
`timescale 1ns/1ps
module tcps_top #(
	parameter int TOGGLE_CYCLES = tcps_pkg::TOGGLE_CYC
) (
	input wire logic clock,
	input wire logic rst,
	input wire tcps_pkg::tcps_tri_t role_strap,
	input wire tcps_pkg::tcps_tri_t addr_strap,
	input wire tcps_pkg::tcps_tri_t cur_strap,
	input wire logic cc_ctrl_enable_n,
	input wire logic mux_enable_n,
	input wire logic supply_5v,
	input wire logic soft_reset,
	input wire logic bus_voltage_sense,
	input wire tcps_pkg::tcps_cc_t cc_in,
	input wire logic cable_supply_overcurrent,
	input wire logic reg_change,
	input wire logic irq_clear,
	output tcps_pkg::tcps_od_t od_oe,
	output tcps_pkg::tcps_cfg_t cfg,
	output tcps_pkg::tcps_cur_t adv_current,
	output logic present_source,
	output logic cc_active,
	output logic mux_active,
	output logic mux_select,
	output logic attached
);
	import tcps_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	function automatic tcps_role_t role_of(input tcps_tri_t t);
		case (t)
			TRI_HIGH: role_of = ROLE_SRC;
			TRI_LOW: role_of = ROLE_SNK;
			default: role_of = ROLE_DRP;
		endcase
	endfunction : role_of

	function automatic tcps_cur_t cur_of(input tcps_tri_t t);
		case (t)
			TRI_MID: cur_of = CUR_MED;
			TRI_HIGH: cur_of = CUR_HIGH;
			default: cur_of = CUR_DEF;
		endcase
	endfunction : cur_of

	////////////////////////////////////////////////////////////////////////////
	// strap sampling
	logic en_q;
	tcps_cfg_t cfg_q;
	tcps_cur_t cur_strap_q;
	tcps_cfg_t cfg_d;
	wire logic enabled = !cc_ctrl_enable_n && supply_5v;
	// RQ2: sample on enable, or on soft reset while enabled
	wire logic sample = (enabled && !en_q) || (enabled && soft_reset);
	// RQ1: role strap decode
	assign cfg_d.role = role_of(role_strap);
	// RQ4: address strap decode
	assign cfg_d.serial_mode = addr_strap != TRI_MID;
	assign cfg_d.dev_addr = addr_strap == TRI_HIGH ? ADDR_STRAP_HIGH :
		addr_strap == TRI_LOW ? ADDR_STRAP_LOW : 7'h00;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			en_q <= 1'b0;
			cfg_q <= '{role: ROLE_DRP, serial_mode: 1'b0, dev_addr: 7'h00};
			cur_strap_q <= CUR_DEF;
		end else begin
			en_q <= enabled;
			// RQ17: hold until next sample
			if (sample) begin
				cfg_q <= cfg_d;
				cur_strap_q <= cur_of(cur_strap);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// attach state machine
	tcps_state_t st_q;
	tcps_state_t st_d;
	logic [TOGGLE_W-1:0] tog_q;
	logic [TOGGLE_W-1:0] tog_d;
	logic orient_q;
	logic src_att_q;
	wire logic snk_seen = cc_in.cc1_rd || cc_in.cc2_rd;
	wire logic src_seen = (cc_in.cc1_rp || cc_in.cc2_rp) && bus_voltage_sense;
	wire logic tog_done = tog_q == TOGGLE_W'(TOGGLE_CYCLES - 1);
	wire logic is_drp = cfg_q.role == ROLE_DRP;
	wire tcps_state_t st_start = cfg_q.role == ROLE_SNK ? ST_UNATT_SNK : ST_UNATT_SRC;

	always_comb begin
		st_d = st_q;
		tog_d = tog_done ? '0 : tog_q + 1'b1;
		case (st_q)
			ST_OFF: begin
				tog_d = '0;
				if (en_q) begin
					st_d = st_start;
				end
			end
			ST_UNATT_SRC: begin
				if (snk_seen) begin
					st_d = ST_ATTACHED;
				// RQ15: toggle to sink
				end else if (is_drp && tog_done) begin
					st_d = ST_UNATT_SNK;
				end
			end
			ST_UNATT_SNK: begin
				// RQ14: vbus marks sink attach
				if (src_seen) begin
					st_d = ST_ATTACHED;
				// RQ15: toggle to source
				end else if (is_drp && tog_done) begin
					st_d = ST_UNATT_SRC;
				end
			end
			ST_ATTACHED: begin
				tog_d = '0;
				if (src_att_q ? !snk_seen : !bus_voltage_sense) begin
					st_d = st_start;
				end
			end
			default: st_d = ST_OFF;
		endcase
		if (!en_q || sample) begin
			st_d = ST_OFF;
		end
	end

	// RQ13: cc logic runs only when enabled
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_q <= ST_OFF;
			tog_q <= '0;
			orient_q <= 1'b0;
			src_att_q <= 1'b0;
		end else begin
			st_q <= st_d;
			tog_q <= tog_d;
			if (st_q != ST_ATTACHED && st_d == ST_ATTACHED) begin
				src_att_q <= st_q == ST_UNATT_SRC;
				// RQ16: orientation from cc wire
				orient_q <= st_q == ST_UNATT_SRC ? cc_in.cc2_rd : cc_in.cc2_rp;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status outputs
	logic irq_q;
	wire logic att = st_q == ST_ATTACHED;
	wire logic snk_att = att && !src_att_q;
	wire logic pin_mode = !cfg_q.serial_mode;
	// RQ5: interrupt set wins over clear
	wire logic irq_d = cfg_q.serial_mode && (reg_change || (irq_q && !irq_clear));

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
			od_oe <= '0;
			cfg <= '{role: ROLE_DRP, serial_mode: 1'b0, dev_addr: 7'h00};
			adv_current <= CUR_DEF;
			present_source <= 1'b0;
			cc_active <= 1'b0;
			mux_active <= 1'b0;
			mux_select <= 1'b0;
			attached <= 1'b0;
		end else begin
			irq_q <= irq_d;
			// RQ5: serial mode interrupt
			// RQ6: pin mode audio status
			od_oe.irq_or_audio_status_pin_oe <= cfg_q.serial_mode ? irq_d :
				(en_q && cc_in.audio);
			// RQ7: status a low unless default
			od_oe.current_status_a_oe <= pin_mode && snk_att && cc_in.cur != CUR_DEF;
			// RQ8: status b low for high
			od_oe.current_status_b_oe <= pin_mode && snk_att && cc_in.cur == CUR_HIGH;
			// RQ9: fault pulled low
			od_oe.cable_supply_fault_n_oe <= cable_supply_overcurrent;
			// RQ10: source attach pulled low
			od_oe.source_attach_n_oe <= att && src_att_q;
			// RQ11: orientation open drain
			od_oe.orient_oe <= att && !orient_q;
			cfg <= cfg_q;
			// RQ3: current advert for source and dual-role, not sink
			adv_current <= (pin_mode && cfg_q.role != ROLE_SNK) ? cur_strap_q : CUR_DEF;
			present_source <= st_q == ST_UNATT_SRC || (att && src_att_q);
			cc_active <= en_q;
			// RQ12: mux enable low runs
			mux_active <= !mux_enable_n;
			mux_select <= orient_q;
			attached <= att;
		end
	end
endmodule : tcps_top

// ==== verif/tcps_top_sva.sv ====
// tcps_top_sva: port checks for tcps_top
// assumes one clock domain, bound in below
`timescale 1ns/1ps
module tcps_top_sva (
	input wire logic clock,
	input wire logic rst,
	input wire logic cc_ctrl_enable_n,
	input wire logic mux_enable_n,
	input wire logic cable_supply_overcurrent,
	input wire logic reg_change,
	input wire tcps_pkg::tcps_od_t od_oe,
	input wire tcps_pkg::tcps_cfg_t cfg,
	input wire tcps_pkg::tcps_cur_t adv_current,
	input wire logic cc_active,
	input wire logic mux_active,
	input wire logic mux_select,
	input wire logic attached
);
	import tcps_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// config settled for two edges
	sequence s_quiet;
		!$past(rst) && $stable(cfg) ##1 $stable(cfg);
	endsequence
	a_mux_follow: assert property (!$past(rst) |-> mux_active == !$past(mux_enable_n))
		else $error("mux run state wrong");
	a_fault_follow: assert property (!$past(rst) |->
		od_oe.cable_supply_fault_n_oe == $past(cable_supply_overcurrent))
		else $error("fault pin wrong");
	a_irq_set: assert property (s_quiet ##0 cfg.serial_mode && reg_change
		|=> od_oe.irq_or_audio_status_pin_oe) else $error("irq not raised");
	a_status_released: assert property (s_quiet ##0 cfg.serial_mode
		|-> !od_oe.current_status_a_oe && !od_oe.current_status_b_oe)
		else $error("status driven in serial mode");
	a_sink_current: assert property (s_quiet ##0 (cfg.serial_mode || cfg.role == ROLE_SNK)
		|-> adv_current == CUR_DEF) else $error("advertised current wrong");
	a_cc_off: assert property (cc_ctrl_enable_n [*3] |-> !cc_active)
		else $error("cc active while disabled");
	a_src_attach: assert property (od_oe.source_attach_n_oe |-> attached && cfg.role != ROLE_SNK)
		else $error("attach pin wrong");
	a_orient_match: assert property (attached && $past(attached) |-> od_oe.orient_oe == !mux_select)
		else $error("orientation mismatch");
endmodule : tcps_top_sva
bind tcps_top tcps_top_sva tcps_top_sva_i (.*);

// ==== verif/tcps_partner.sv ====
// tcps_partner: port partner on the cc wires
// assumes kind 1 sink, 2 source, 3 audio accessory
`timescale 1ns/1ps
module tcps_partner (
	input wire logic [1:0] kind,
	input wire logic flip,
	input wire tcps_pkg::tcps_cur_t cur,
	output tcps_pkg::tcps_cc_t cc,
	output logic vbus
);
	import tcps_pkg::*;
	assign cc = '{cc1_rd: kind == 2'h1 && !flip, cc2_rd: kind == 2'h1 && flip,
		cc1_rp: kind == 2'h2, cc2_rp: 1'b0, cur: cur, audio: kind == 2'h3};
	assign vbus = kind == 2'h2;
endmodule : tcps_partner

// ==== verif/tcps_top_bench.sv ====
// tcps_top_bench: directed scenarios for tcps_top
// assumes tcps_partner on cc side, checker bound in
`timescale 1ns/1ps
module tcps_top_bench;
	import tcps_pkg::*;
	logic clock = 0, rst = 1, en_n = 1, mux_n = 0, ovc = 0, srst = 0, regc = 0, iclr = 0;
	logic flip = 1, vbus, ps, cca, mxa, mxs, att;
	logic [1:0] kind = 2'h1;
	tcps_tri_t role_s = TRI_HIGH, addr_s = TRI_MID, cur_s = TRI_HIGH;
	tcps_cur_t cur = CUR_MED, adv;
	tcps_cc_t cc;
	tcps_od_t od;
	tcps_cfg_t cfg;
	int errors = 0, checks = 0;
	always #2.5 clock = ~clock;
	tcps_partner tcps_partner_i (.kind(kind), .flip(flip), .cur(cur), .cc(cc), .vbus(vbus));
	tcps_top #(.TOGGLE_CYCLES(8)) tcps_top_i (.clock(clock), .rst(rst), .role_strap(role_s),
		.addr_strap(addr_s), .cur_strap(cur_s), .cc_ctrl_enable_n(en_n), .mux_enable_n(mux_n),
		.supply_5v(1'b1), .soft_reset(srst), .bus_voltage_sense(vbus), .cc_in(cc),
		.cable_supply_overcurrent(ovc), .reg_change(regc), .irq_clear(iclr), .od_oe(od),
		.cfg(cfg), .adv_current(adv), .present_source(ps), .cc_active(cca),
		.mux_active(mxa), .mux_select(mxs), .attached(att));
	task chk(input string n, input logic [9:0] e, input logic [9:0] s);
		checks++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task wt(input int n);
		repeat (n) @(negedge clock);
	endtask : wt
	task attach(input logic [1:0] k);
		kind = k;
		en_n = 0;
		for (int i = 0; i < 100 && att !== 1'b1; i++) @(negedge clock);
		wt(2);
	endtask : attach
	task results;
		if (errors == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : results
	task t_source;
		attach(2'h1);
		chk("attach_oe", 1, od.source_attach_n_oe);
		chk("mux_sel", 1, mxs);
		chk("adv", CUR_HIGH, adv);
		chk("orient_oe", 0, od.orient_oe);
		chk("cfg", {ROLE_SRC, 8'h00}, cfg);
		role_s = TRI_LOW;
		wt(4);
		chk("cfg_hold", ROLE_SRC, cfg.role);
		en_n = 1;
		wt(3);
		chk("cc_off", 0, cca);
	endtask : t_source
	task t_sink;
		attach(2'h2);
		chk("sink_att", 1, att);
		chk("role", ROLE_SNK, cfg.role);
		chk("stat_a", 1, od.current_status_a_oe);
		chk("stat_b", 0, od.current_status_b_oe);
		chk("adv_snk", CUR_DEF, adv);
		cur = CUR_HIGH;
		wt(3);
		chk("stat_b_hi", 1, od.current_status_b_oe);
		kind = 2'h3;
		wt(4);
		chk("audio", 1, od.irq_or_audio_status_pin_oe);
	endtask : t_sink
	task t_serial;
		kind = 2'h0;
		for (int i = 0; i < 2; i++) begin
			addr_s = i ? TRI_LOW : TRI_HIGH;
			srst = 1;
			wt(1);
			srst = 0;
			wt(3);
			chk("addr", i ? 8'hC7 : 8'hE7, cfg[7:0]);
		end
		regc = 1;
		wt(1);
		regc = 0;
		wt(1);
		chk("irq_set", 1, od.irq_or_audio_status_pin_oe);
		iclr = 1;
		wt(2);
		chk("irq_clr", 0, od.irq_or_audio_status_pin_oe);
	endtask : t_serial
	task t_drp;
		en_n = 1;
		kind = 2'h0;
		flip = 0;
		role_s = TRI_MID;
		addr_s = TRI_MID;
		wt(2);
		en_n = 0;
		wt(4);
		chk("drp_src", 1, ps);
		wt(10);
		chk("drp_snk", 0, ps);
		wt(8);
		chk("drp_src2", 1, ps);
		attach(2'h1);
		chk("drp_attach_oe", 1, od.source_attach_n_oe);
		chk("drp_mux_sel", 0, mxs);
		chk("drp_orient_oe", 1, od.orient_oe);
		chk("drp_adv", CUR_HIGH, adv);
	endtask : t_drp
	initial begin
		wt(6);
		rst = 0;
		wt(1);
		t_source;
		t_sink;
		t_serial;
		t_drp;
		for (int i = 0; i < 2; i++) begin
			mux_n = i[0];
			ovc = !i[0];
			wt(2);
			chk("mux", !i[0], mxa);
			chk("fault", !i[0], od.cable_supply_fault_n_oe);
		end
		results;
	end
	initial begin
		#20000;
		errors++;
		results;
	end
endmodule : tcps_top_bench
